// File: hdl/serial_drive_map.vh
// register map and field constants for the serial drive control bank
`ifndef SERIAL_DRIVE_MAP_VH
`define SERIAL_DRIVE_MAP_VH
`define FB_WR_FIRST 16'h0568
`define FB_WR_LAST 16'h05A7
`define FB_RD_FIRST 16'h05A8
`define FB_RD_LAST 16'h05E7
`define FB_SLOTS 128
`define FB_IDX_W 7
`define REG_DRIVE_CMD 16'h07D0
`define REG_FREQ_SET 16'h07D1
`define REG_PID_SET 16'h07D2
`define CMD_RESET 16'h0000
`define FREQ_RESET 16'h0000
`define PID_RESET 16'h0000
`define CMD_FAULT_BIT 1
`define CMD_FORCE_PID_BIT 4
`define CMD_FORCE_FREQ_BIT 5
`define CMD_FORCE_START_BIT 6
`define CMD_BLOCK_PARAM_BIT 12
`define CMD_BLOCK_RAMP_BIT 13
`define CMD_BLOCK_COAST_BIT 14
`define CMD_START_BIT 15
`define FREQ_MAX 16'sh1388
`define FREQ_MIN -16'sh1388
`define PID_MAX 16'h03E8
`define ZERO16 16'h0000
`define STOP_NONE 2'h0
`define STOP_PARAM 2'h1
`define STOP_RAMP 2'h2
`define STOP_COAST 2'h3
`endif

// File: hdl/fault_clear_detect.v
// detects a low-high-low sequence on the fault clear command bit
`timescale 1ns/1ps
module fault_clear_detect (
	input wire mclk,
	input wire reset_n,
	input wire update,
	input wire level,
	output reg clearPulse
);
	localparam S_WAIT_LOW = 2'h0;
	localparam S_SEEN_LOW = 2'h1;
	localparam S_SEEN_HIGH = 2'h2;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg clear_d;
	always @* begin
		state_d = state_q;
		clear_d = 1'b0;
		if (update) begin
			case (state_q)
			S_WAIT_LOW: begin
				if (!level)
					state_d = S_SEEN_LOW;
			end
			S_SEEN_LOW: begin
				if (level)
					state_d = S_SEEN_HIGH;
			end
			S_SEEN_HIGH: begin
				if (!level) begin
					clear_d = 1'b1; // R6
					state_d = S_SEEN_LOW;
				end
			end
			default: state_d = S_WAIT_LOW;
			endcase
		end
	end
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= S_WAIT_LOW;
			clearPulse <= 1'b0;
		end else begin
			state_q <= state_d;
			clearPulse <= clear_d;
		end
	end
endmodule

// File: hdl/serial_drive_control_registers.v
// register bank for link control of the drive: function block windows, command, setpoints
//
// What this block does
// R1 - every register holds 16 bits; unlisted addresses are unsupported
// R2 - lower function block window is readable and writable by the link
// R3 - upper function block window is readable; link writes are ignored
// R4 - drive command acts only while link control is permitted
// R5 - without permission, link-sourced start stays stopped and references read zero
// R6 - fault clears after command bit 1 goes low, high, low
// R7 - bits 4, 5, 6 force PID, frequency, start source onto the link
// R8 - while forced, the configured source is disconnected
// R9 - a source already configured as link needs no forcing bit
// R10 - bits 12, 13, 14 block: configured stop, ramp stop, coast
// R11 - any block bit stops the drive and beats a link start
// R12 - bit 15 one requests start, zero requests stop
// R13 - bits 0, 2, 3, 7 to 11 have no effect
// R14 - command read returns the last written value
// R15 - frequency setpoint is signed tenths of hertz, active only with permission
// R16 - frequency setpoint accepted within plus or minus 5000
// R17 - in vector modes the frequency setpoint means rpm
// R18 - PID setpoint is 0 to 1000 tenths of percent, active only with permission
// R19 - writes to read-only or unsupported addresses change nothing
`timescale 1ns/1ps
`include "serial_drive_map.vh"
module serial_drive_control_registers (
	input wire mclk,
	input wire reset_n,
	input wire regWrite,
	input wire regRead,
	input wire [15:0] regAddr,
	input wire [15:0] regWdata,
	output reg [15:0] regRdata,
	output reg regAck,
	output reg regError,
	input wire linkControlPermission,
	input wire vectorControlMode,
	input wire startSourceIsLink,
	input wire freqSourceIsLink,
	input wire pidSourceIsLink,
	input wire cfgStartRequest,
	input wire [15:0] cfgFreqRef,
	input wire [15:0] cfgPidRef,
	input wire fbReadWe,
	input wire [5:0] fbReadIdx,
	input wire [15:0] fbReadData,
	input wire [5:0] fbWriteIdx,
	output reg [15:0] fbWriteData,
	output reg driveRun,
	output reg [1:0] stopMode,
	output reg [15:0] freqRef,
	output reg freqIsRpm,
	output reg [15:0] pidRef,
	output reg faultClear
);
	reg [15:0] fbSlots [0:`FB_SLOTS-1];
	reg [15:0] driveCommand_q;
	reg [15:0] freqSetpoint_q;
	reg [15:0] pidSetpoint_q;
	reg cmdUpdate_q;
	reg permitMeta_q;
	reg permit_q;
	wire faultClearPulse;
	wire [2:0] addrCls;
	wire addrFbWr;
	wire addrFbRd;
	wire addrCmd;
	wire addrFreq;
	wire addrPid;
	wire addrKnown;
	wire [15:0] accOffset;
	wire [`FB_IDX_W-1:0] accIdx;
	wire freqInRange;
	wire pidInRange;
	wire wrFb;
	wire wrCmd;
	wire wrFreq;
	wire wrPid;
	wire wrRefused;
	wire forcePid;
	wire forceFreq;
	wire forceStart;
	wire blockParam;
	wire blockRamp;
	wire blockCoast;
	wire linkStart;
	wire startFromLink;
	wire freqFromLink;
	wire pidFromLink;
	wire anyBlock;
	reg [15:0] rdData_d;
	reg run_d;
	reg [1:0] stop_d;
	reg [15:0] freq_d;
	reg [15:0] pid_d;

	// address classes shared by the read and write decode
	localparam CLS_NONE = 3'h0;
	localparam CLS_FB_WR = 3'h1;
	localparam CLS_FB_RD = 3'h2;
	localparam CLS_CMD = 3'h3;
	localparam CLS_FREQ = 3'h4;
	localparam CLS_PID = 3'h5;

	// permission may come from a digital input: synchronise it
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			permitMeta_q <= 1'b0;
			permit_q <= 1'b0;
		end else begin
			permitMeta_q <= linkControlPermission;
			permit_q <= permitMeta_q;
		end
	end

	function inRange;
		input [15:0] a;
		input [15:0] lo;
		input [15:0] hi;
		begin
			inRange = (a >= lo) && (a <= hi);
		end
	endfunction

	// link value when permitted; zero when the link owns the source but may not act
	function [15:0] refSelect;
		input fromLink;
		input permit;
		input [15:0] linkValue;
		input [15:0] cfgValue;
		begin
			if (!fromLink)
				refSelect = cfgValue;
			else if (permit)
				refSelect = linkValue;
			else
				refSelect = `ZERO16;
		end
	endfunction

	// coast outranks ramp, ramp outranks the configured stop
	function [1:0] stopKind;
		input enable;
		input param;
		input ramp;
		input coast;
		begin
			if (!enable)
				stopKind = `STOP_NONE;
			else if (coast)
				stopKind = `STOP_COAST;
			else if (ramp)
				stopKind = `STOP_RAMP;
			else if (param)
				stopKind = `STOP_PARAM;
			else
				stopKind = `STOP_NONE;
		end
	endfunction

	// windows first, then the single registers
	function [2:0] addrClass;
		input [15:0] a;
		begin
			if (inRange(a, `FB_WR_FIRST, `FB_WR_LAST))
				addrClass = CLS_FB_WR;
			else if (inRange(a, `FB_RD_FIRST, `FB_RD_LAST))
				addrClass = CLS_FB_RD;
			else if (a == `REG_DRIVE_CMD)
				addrClass = CLS_CMD;
			else if (a == `REG_FREQ_SET)
				addrClass = CLS_FREQ;
			else if (a == `REG_PID_SET)
				addrClass = CLS_PID;
			else
				addrClass = CLS_NONE;
		end
	endfunction

	assign addrCls = addrClass(regAddr);
	assign addrFbWr = (addrCls == CLS_FB_WR);
	assign addrFbRd = (addrCls == CLS_FB_RD);
	assign addrCmd = (addrCls == CLS_CMD);
	assign addrFreq = (addrCls == CLS_FREQ);
	assign addrPid = (addrCls == CLS_PID);
	assign addrKnown = (addrCls != CLS_NONE); // R1
	// both windows are contiguous, so one offset indexes all the slots
	assign accOffset = regAddr - `FB_WR_FIRST;
	assign accIdx = accOffset[`FB_IDX_W-1:0];
	assign freqInRange = ($signed(regWdata) >= `FREQ_MIN) &&
		($signed(regWdata) <= `FREQ_MAX); // R16
	assign pidInRange = (regWdata <= `PID_MAX); // R18

	// accepted writes per target; anything else is refused and stores nothing
	assign wrFb = regWrite & addrFbWr; // R2
	assign wrCmd = regWrite & addrCmd; // R14
	assign wrFreq = regWrite & addrFreq & freqInRange; // R15
	assign wrPid = regWrite & addrPid & pidInRange; // R18
	assign wrRefused = regWrite & ~(wrFb | wrCmd | wrFreq | wrPid); // R19

	// function block slots: lower half link-writable, upper half fed by the drive
	// slots are not cleared by reset; they are undefined until first written
	always @(posedge mclk) begin
		if (wrFb)
			fbSlots[accIdx] <= regWdata; // R2
		if (fbReadWe)
			fbSlots[{1'b1, fbReadIdx}] <= fbReadData; // R3
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			fbWriteData <= `ZERO16;
		else
			fbWriteData <= fbSlots[{1'b0, fbWriteIdx}];
	end

	// writable registers; rejected writes leave contents intact
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			driveCommand_q <= `CMD_RESET;
			cmdUpdate_q <= 1'b0;
		end else begin
			cmdUpdate_q <= wrCmd;
			if (wrCmd)
				driveCommand_q <= regWdata; // R14
		end
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			freqSetpoint_q <= `FREQ_RESET;
		else if (wrFreq)
			freqSetpoint_q <= regWdata; // R15
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			pidSetpoint_q <= `PID_RESET;
		else if (wrPid)
			pidSetpoint_q <= regWdata; // R18
	end

	always @* begin
		case (addrCls)
		CLS_FB_WR: rdData_d = fbSlots[accIdx]; // R2
		CLS_FB_RD: rdData_d = fbSlots[accIdx]; // R3
		CLS_CMD: rdData_d = driveCommand_q; // R14
		CLS_FREQ: rdData_d = freqSetpoint_q;
		CLS_PID: rdData_d = pidSetpoint_q;
		default: rdData_d = `ZERO16;
		endcase
	end

	// one-cycle answer to every strobe
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			regAck <= 1'b0;
		else
			regAck <= regWrite | regRead;
	end

	// read data holds until the next read
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			regRdata <= `ZERO16;
		else if (regRead)
			regRdata <= rdData_d;
	end

	// a write and a read in one cycle report the write's outcome
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			regError <= 1'b0;
		else if (regWrite)
			regError <= wrRefused; // R19
		else
			regError <= regRead & ~addrKnown; // R1
	end

	fault_clear_detect faultSeq (
		.mclk(mclk),
		.reset_n(reset_n),
		.update(cmdUpdate_q & permit_q),
		.level(driveCommand_q[`CMD_FAULT_BIT]),
		.clearPulse(faultClearPulse)
	);

	// drive control decode; unused command bits are never read
	assign forcePid = driveCommand_q[`CMD_FORCE_PID_BIT]; // R13
	assign forceFreq = driveCommand_q[`CMD_FORCE_FREQ_BIT];
	assign forceStart = driveCommand_q[`CMD_FORCE_START_BIT];
	assign blockParam = driveCommand_q[`CMD_BLOCK_PARAM_BIT];
	assign blockRamp = driveCommand_q[`CMD_BLOCK_RAMP_BIT];
	assign blockCoast = driveCommand_q[`CMD_BLOCK_COAST_BIT];
	assign linkStart = driveCommand_q[`CMD_START_BIT];
	assign startFromLink = startSourceIsLink | (permit_q & forceStart); // R7 R9
	assign freqFromLink = freqSourceIsLink | (permit_q & forceFreq); // R7 R9
	assign pidFromLink = pidSourceIsLink | (permit_q & forcePid); // R7 R9
	assign anyBlock = permit_q & (blockParam | blockRamp | blockCoast); // R4 R10

	// forced or link source replaces the configured one entirely
	always @* begin
		if (startFromLink)
			run_d = permit_q & linkStart; // R5 R8 R12
		else
			run_d = cfgStartRequest;
		if (anyBlock)
			run_d = 1'b0; // R11
	end

	always @* begin
		stop_d = stopKind(permit_q, blockParam, blockRamp, blockCoast); // R10
		freq_d = refSelect(freqFromLink, permit_q, freqSetpoint_q, cfgFreqRef); // R5 R8 R15
		pid_d = refSelect(pidFromLink, permit_q, pidSetpoint_q, cfgPidRef); // R5 R8 R18
	end

	// run and stop kind update on the same clock edge
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			driveRun <= 1'b0;
			stopMode <= `STOP_NONE;
		end else begin
			driveRun <= run_d;
			stopMode <= stop_d;
		end
	end

	// references follow their source one cycle after it changes
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			freqRef <= `ZERO16;
			pidRef <= `ZERO16;
		end else begin
			freqRef <= freq_d;
			pidRef <= pid_d;
		end
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			freqIsRpm <= 1'b0;
			faultClear <= 1'b0;
		end else begin
			freqIsRpm <= vectorControlMode; // R17
			faultClear <= faultClearPulse; // R6
		end
	end
endmodule

// File: dv/serial_drive_control_registers_props.sv
// assertions on the serial drive register bank ports
`timescale 1ns/1ps
module serial_drive_control_registers_props (
	input wire mclk,
	input wire reset_n,
	input wire regWrite,
	input wire regRead,
	input wire [15:0] regAddr,
	input wire [15:0] regWdata,
	input wire regAck,
	input wire regError,
	input wire linkControlPermission,
	input wire vectorControlMode,
	input wire startSourceIsLink,
	input wire driveRun,
	input wire [1:0] stopMode,
	input wire freqIsRpm,
	input wire faultClear
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence s_req;
		regWrite || regRead;
	endsequence
	sequence s_wr(a);
		regWrite && regAddr == a;
	endsequence
	a_ack_follows: assert property (s_req |=> regAck) else $error("no ack");
	a_no_stray_ack: assert property (!(regWrite || regRead) |=> !regAck) else $error("stray ack");
	a_unmapped_err: assert property (s_req ##0 regAddr > 16'h07D2 |=> regError) else $error("unmapped");
	a_ro_write: assert property (regWrite && regAddr >= 16'h05A8 && regAddr <= 16'h05E7
		|=> regError) else $error("ro write");
	a_freq_range: assert property (s_wr(16'h07D1) ##0 $signed(regWdata) > 5000
		|=> regError) else $error("freq range");
	a_pid_range: assert property (s_wr(16'h07D2) ##0 regWdata > 16'h03E8
		|=> regError) else $error("pid range");
	a_rpm_mode: assert property (freqIsRpm == $past(vectorControlMode)) else $error("rpm");
	a_no_perm_stop: assert property ((!linkControlPermission && startSourceIsLink) [*4]
		|-> !driveRun) else $error("run w/o perm");
	a_block_stops: assert property (stopMode != 2'h0 |-> !driveRun) else $error("block");
	a_fault_pulse: assert property (faultClear |=> !faultClear) else $error("fault pulse");
endmodule
bind serial_drive_control_registers serial_drive_control_registers_props u_props (.*);

// File: dv/modbus_master_model.sv
// link master model issuing single word register transfers
`timescale 1ns/1ps
module modbus_master_model (
	input wire mclk,
	input wire regAck,
	input wire regError,
	input wire [15:0] regRdata,
	output logic regWrite = 1'b0,
	output logic regRead = 1'b0,
	output logic [15:0] regAddr = 16'h0000,
	output logic [15:0] regWdata = 16'h0000
);
	// a missing ack returns an unknown error flag so the caller mismatches
	task automatic xfer(input logic w, input logic [15:0] a, d, output logic [15:0] rd,
		output logic err);
		@(negedge mclk);
		regWrite = w;
		regRead = !w;
		regAddr = a;
		regWdata = d;
		@(negedge mclk);
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = ~a;
		regWdata = ~d;
		rd = regRdata;
		err = (regAck === 1'b1) ? regError : 1'bx;
	endtask
endmodule

// File: dv/serial_drive_control_registers_bench.sv
// self-checking bench for the serial drive register bank
`timescale 1ns/1ps
`include "serial_drive_map.vh"
module serial_drive_control_registers_bench;
	logic mclk = 1'b0, reset_n = 1'b0, linkControlPermission = 1'b0, vectorControlMode = 1'b0;
	logic startSourceIsLink = 1'b0, freqSourceIsLink = 1'b1, pidSourceIsLink = 1'b1;
	logic cfgStartRequest = 1'b0, fbReadWe = 1'b0, er, seen;
	logic [15:0] cfgFreqRef = 16'h0077, cfgPidRef = 16'h0055, fbReadData = 16'h3C5A, rd;
	logic [5:0] fbReadIdx = 6'h3F, fbWriteIdx = 6'h3F;
	wire regWrite, regRead, regAck, regError, driveRun, freqIsRpm, faultClear;
	wire [15:0] regAddr, regWdata, regRdata, fbWriteData, freqRef, pidRef;
	wire [1:0] stopMode;
	integer error_cnt = 0, checks = 0;
	always #2.5 mclk = ~mclk;
	serial_drive_control_registers DUT (.*);
	modbus_master_model master (.*);
	task automatic chk(input string n, input logic [15:0] e, s);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [15:0] a, d, input logic e);
		master.xfer(1'b1, a, d, rd, er);
		chk("write error flag", {15'h0000, e}, {15'h0000, er});
	endtask
	task automatic rdc(input logic [15:0] a, e);
		master.xfer(1'b0, a, 16'h0000, rd, er);
		chk("read error flag", 16'h0000, {15'h0000, er});
		chk("read data", e, rd);
	endtask
	task automatic cmd(input logic [15:0] d, input logic run, input logic [1:0] sm);
		wr(`REG_DRIVE_CMD, d, 1'b0);
		repeat (2) @(negedge mclk);
		chk("drive run", {15'h0000, run}, {15'h0000, driveRun});
		chk("stop kind", {14'h0000, sm}, {14'h0000, stopMode});
	endtask
	task automatic t_window;
		wr(`FB_WR_LAST, 16'hA5C3, 1'b0);
		rdc(`FB_WR_LAST, 16'hA5C3);
		@(negedge mclk);
		chk("slot out", 16'hA5C3, fbWriteData);
		fbReadWe = 1'b1;
		@(negedge mclk);
		fbReadWe = 1'b0;
		wr(`FB_RD_LAST, 16'h1111, 1'b1);
		rdc(`FB_RD_LAST, 16'h3C5A);
		wr(16'h07D3, 16'h1111, 1'b1);
		$display("window test done");
	endtask
	task automatic t_cmd;
		linkControlPermission = 1'b1;
		cfgStartRequest = 1'b1;
		repeat (3) @(negedge mclk);
		cmd(16'h8FCD, 1'b1, 2'h0);
		rdc(`REG_DRIVE_CMD, 16'h8FCD);
		cmd(16'h0FCD, 1'b0, 2'h0);
		for (int i = 1; i < 4; i++) cmd(16'h8FCD | (16'h0800 << i), 1'b0, i[1:0]);
		cmd(16'h8F8D, 1'b1, 2'h0);
		$display("command test done");
	endtask
	task automatic t_set;
		wr(`REG_FREQ_SET, 16'h00FA, 1'b0);
		wr(`REG_FREQ_SET, 16'h1389, 1'b1);
		wr(`REG_FREQ_SET, 16'hEC77, 1'b1);
		wr(`REG_PID_SET, 16'h03E9, 1'b1);
		wr(`REG_PID_SET, 16'h03E8, 1'b0);
		vectorControlMode = 1'b1;
		repeat (2) @(negedge mclk);
		chk("freq ref", 16'h00FA, freqRef);
		chk("pid ref", 16'h03E8, pidRef);
		chk("rpm flag", 16'h0001, {15'h0000, freqIsRpm});
		wr(`REG_FREQ_SET, 16'hEC78, 1'b0);
		rdc(`REG_FREQ_SET, 16'hEC78);
		freqSourceIsLink = 1'b0;
		pidSourceIsLink = 1'b0;
		repeat (2) @(negedge mclk);
		chk("cfg freq ref", 16'h0077, freqRef);
		chk("cfg pid ref", 16'h0055, pidRef);
		cmd(16'h0030, 1'b1, 2'h0);
		chk("forced freq ref", 16'hEC78, freqRef);
		chk("forced pid ref", 16'h03E8, pidRef);
		freqSourceIsLink = 1'b1;
		pidSourceIsLink = 1'b1;
		$display("setpoint test done");
	endtask
	task automatic t_fault;
		wr(`REG_DRIVE_CMD, 16'h0000, 1'b0);
		wr(`REG_DRIVE_CMD, 16'h0002, 1'b0);
		wr(`REG_DRIVE_CMD, 16'h0000, 1'b0);
		seen = 1'b0;
		for (int i = 0; i < 4; i++) begin
			seen = seen | faultClear;
			@(negedge mclk);
		end
		chk("fault clear", 16'h0001, {15'h0000, seen});
		$display("fault test done");
	endtask
	task automatic t_perm;
		linkControlPermission = 1'b0;
		startSourceIsLink = 1'b1;
		cmd(16'h8000, 1'b0, 2'h0);
		repeat (2) @(negedge mclk);
		chk("ref w/o perm", 16'h0000, freqRef);
		linkControlPermission = 1'b1;
		repeat (4) @(negedge mclk);
		chk("run with perm", 16'h0001, {15'h0000, driveRun});
		$display("permission test done");
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge mclk);
		reset_n = 1'b1;
		t_window;
		t_cmd;
		t_set;
		t_fault;
		t_perm;
		close_out;
	end
endmodule
